// ---- shared/converter_map.vh ----
// Register indices, field positions and reset values of the four-channel converter control
`ifndef CONVERTER_MAP_VH
`define CONVERTER_MAP_VH
`define CTRL_IDX        3'h0
`define LEVEL0_IDX      3'h1
`define LEVEL1_IDX      3'h2
`define LEVEL2_IDX      3'h3
`define LEVEL3_IDX      3'h4
`define ENABLE_LSB      0
`define ENABLE_MSB      3
`define CTRL_RESET      8'h00
`define LEVEL_RESET     8'h00
`define ZERO_CODE       8'h00
`endif

// ---- src/level_store.v ----
// Four byte-wide channel level registers with registered read data
module level_store (
    // Clock and control
    input  wire       clk,
    input  wire       rstn,
    input  wire       ce,
    // Write port
    input  wire       wr_en,
    input  wire [1:0] wr_sel,
    input  wire [7:0] wr_data,
    // Read port
    input  wire [1:0] rd_sel,
    output reg  [7:0] rd_data,
    // All levels, flat, channel 0 in the low byte
    output wire [31:0] levels
);
`include "converter_map.vh"

    reg [7:0] mem_q [0:3];
    integer i;

    assign levels = {mem_q[3], mem_q[2], mem_q[1], mem_q[0]};

    always @(posedge clk) begin
        if (!rstn) begin
            for (i = 0; i < 4; i = i + 1) begin
                mem_q[i] <= `LEVEL_RESET;
            end
            rd_data <= `LEVEL_RESET;
        end else if (ce) begin
            if (wr_en) begin
                mem_q[wr_sel] <= wr_data;
            end
            rd_data <= mem_q[rd_sel];
        end
    end
endmodule

// ---- src/converter_ctrl.v ----
// Control logic of the four-channel 8-bit output converter
module converter_ctrl (
    // Clock, reset and enable
    input  wire        clk,
    input  wire        rstn,
    input  wire        ce,
    // Hardware reset pin, active high pulse
    input  wire        hardware_reset_pin,
    // Chip idle mode
    input  wire        idle_mode,
    // Peripheral register port
    input  wire [2:0]  reg_addr,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    output reg         reg_rvalid,
    // Converter codes, channel 0 in the low byte
    output reg  [31:0] analog_out_pins,
    output reg  [3:0]  channel_active,
    output reg  [3:0]  conv_start,
    output reg         converter_run
);
`include "converter_map.vh"

    // Stored control state and read tracking
    reg  [3:0]  channel_enable_bits_q;
    reg         rd_ctrl_q;
    reg  [2:0]  rd_addr_q;
    // Level store side
    wire [7:0]  store_rdata;
    wire [31:0] channel_level_regs;
    // Decoded requests and gating
    wire [7:0]  ctrl_reset_val;
    wire [7:0]  ctrl_view;
    wire        any_reset;
    wire        ctrl_wr;
    wire        ctrl_rd;
    wire        level_wr;
    wire [1:0]  level_idx;
    wire [3:0]  level_hot;
    wire [3:0]  live;
    wire        any_live;
    // Next values of the registered outputs
    reg  [31:0] pins_d;
    reg  [3:0]  start_d;

    // Index decoding shared by the write, read and pulse paths
    function is_ctrl;
        input [2:0] a;
        begin
            is_ctrl = (a == `CTRL_IDX);
        end
    endfunction

    function is_level;
        input [2:0] a;
        begin
            is_level = (a >= `LEVEL0_IDX) && (a <= `LEVEL3_IDX);
        end
    endfunction

    function [1:0] level_sel;
        input [2:0] a;
        reg   [2:0] d;
        begin
            d = a - `LEVEL0_IDX;
            level_sel = d[1:0];
        end
    endfunction

    function [3:0] level_onehot;
        input [2:0] a;
        begin
            if (is_level(a)) begin
                level_onehot = 4'h1 << level_sel(a);
            end else begin
                level_onehot = 4'h0;
            end
        end
    endfunction

    // Disabled or idle channels send code zero, which the stage turns into ground
    function [7:0] gate_code;
        input       on;
        input [7:0] code;
        begin
            if (on) begin
                gate_code = code;
            end else begin
                gate_code = `ZERO_CODE;
            end
        end
    endfunction

    // Warm reset from the pin acts like the power-up reset
    assign any_reset      = !rstn || hardware_reset_pin;
    assign ctrl_reset_val = `CTRL_RESET;
    // Reserved bits are not stored, so they read back as zero
    assign ctrl_view      = {4'h0, channel_enable_bits_q};
    assign ctrl_wr        = reg_wr && is_ctrl(reg_addr);
    assign ctrl_rd        = reg_rd && is_ctrl(reg_addr);
    assign level_wr       = reg_wr && is_level(reg_addr);
    assign level_idx      = level_sel(reg_addr);
    // One-hot of the channel whose level is written in this cycle
    assign level_hot      = level_wr ? level_onehot(reg_addr) : 4'h0;
    // Idle gates only the outputs, never the stored values
    assign live           = idle_mode ? 4'h0 : channel_enable_bits_q;
    assign any_live       = |live;

    level_store u_store (
        .clk     (clk),
        .rstn    (!any_reset),
        .ce      (ce),
        .wr_en   (level_wr),
        .wr_sel  (level_idx),
        .wr_data (reg_wdata),
        .rd_sel  (level_idx),
        .rd_data (store_rdata),
        .levels  (channel_level_regs)
    );

    always @(posedge clk) begin
        if (any_reset) begin
            channel_enable_bits_q <= ctrl_reset_val[`ENABLE_MSB:`ENABLE_LSB];
        end else if (ce && ctrl_wr) begin
            // Upper bits are dropped on write
            channel_enable_bits_q <= reg_wdata[`ENABLE_MSB:`ENABLE_LSB];
        end
    end

    // Read index is captured on every cycle with ce high; reg_rvalid says when it counts
    always @(posedge clk) begin
        if (any_reset) begin
            rd_ctrl_q  <= 1'b0;
            rd_addr_q  <= 3'h0;
            reg_rvalid <= 1'b0;
        end else if (ce) begin
            rd_ctrl_q  <= ctrl_rd;
            rd_addr_q  <= reg_addr;
            reg_rvalid <= reg_rd;
        end
    end

    // Read data is a mux of registers, so it stands as long as reg_rvalid
    always @* begin
        case (rd_addr_q)
            `CTRL_IDX: begin
                reg_rdata = rd_ctrl_q ? ctrl_view : 8'h00;
            end
            `LEVEL0_IDX, `LEVEL1_IDX, `LEVEL2_IDX, `LEVEL3_IDX: begin
                reg_rdata = store_rdata;
            end
            default: begin
                reg_rdata = 8'h00;
            end
        endcase
    end

    // Codes of live channels go out unchanged: the analog stage is linear and unsigned
    always @* begin
        pins_d[7:0]   = gate_code(live[0], channel_level_regs[7:0]);
        pins_d[15:8]  = gate_code(live[1], channel_level_regs[15:8]);
        pins_d[23:16] = gate_code(live[2], channel_level_regs[23:16]);
        pins_d[31:24] = gate_code(live[3], channel_level_regs[31:24]);
    end

    always @* begin
        start_d = live & level_hot;
    end

    always @(posedge clk) begin
        if (any_reset) begin
            analog_out_pins <= {4{`ZERO_CODE}};
        end else if (ce) begin
            analog_out_pins <= pins_d;
        end
    end

    // Per-channel live view, registered together with the codes
    always @(posedge clk) begin
        if (any_reset) begin
            channel_active <= 4'h0;
        end else if (ce) begin
            channel_active <= live;
        end
    end

    // Run flag lets the analog stage power down when nothing is live
    always @(posedge clk) begin
        if (any_reset) begin
            converter_run <= 1'b0;
        end else if (ce) begin
            converter_run <= any_live;
        end
    end

    // Pulse marks a new conversion on each level write to a live channel
    always @(posedge clk) begin
        if (any_reset) begin
            conv_start <= 4'h0;
        end else if (ce) begin
            conv_start <= start_d;
        end
    end
endmodule

// ---- tb/converter_ctrl_properties.sv ----
// Port assertions for the converter control
module converter_ctrl_props (
    input wire logic        clk, rstn, ce, hardware_reset_pin, idle_mode,
    input wire logic        reg_wr, reg_rd, reg_rvalid, converter_run,
    input wire logic [2:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic [3:0]  channel_active, conv_start,
    input wire logic [31:0] analog_out_pins
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire logic [31:0] live = {{8{channel_active[3]}}, {8{channel_active[2]}},
                              {8{channel_active[1]}}, {8{channel_active[0]}}};
    sequence calm; ce && !idle_mode && !hardware_reset_pin; endsequence
    sequence ctrl_wr; calm ##0 reg_wr && reg_addr == 3'h0; endsequence
    chk_idle_zero: assert property (idle_mode && ce |=> analog_out_pins == 0 && channel_active == 0)
        else $error("idle output");
    chk_off_zero: assert property ((analog_out_pins & ~live) == 0)
        else $error("disabled output");
    chk_run_any: assert property (converter_run == |channel_active)
        else $error("run flag");
    chk_read_answer: assert property (reg_rd && ce && !hardware_reset_pin |=> reg_rvalid)
        else $error("read answer");
    chk_start_cause: assert property (conv_start != 0 |-> $past(reg_wr) &&
        conv_start == 4'h1 << ($past(reg_addr) - 3'h1))
        else $error("start pulse");
    chk_hw_reset: assert property (hardware_reset_pin && ce |=> channel_active == 0 && analog_out_pins == 0)
        else $error("warm reset");
    chk_reset_clear: assert property ($rose(rstn) |-> channel_active == 0 && analog_out_pins == 0)
        else $error("reset output");
    chk_enable_lag: assert property (ctrl_wr ##1 calm ##0 !reg_wr |=> channel_active == $past(reg_wdata[3:0], 2))
        else $error("enable bits");
endmodule
bind converter_ctrl converter_ctrl_props u_props (.clk, .rstn, .ce, .hardware_reset_pin, .idle_mode, .reg_wr,
    .reg_rd, .reg_rvalid, .converter_run, .reg_addr, .reg_wdata, .channel_active, .conv_start, .analog_out_pins);

// ---- tb/analog_load.sv ----
// Load model turning output codes into millivolts
module analog_load #(parameter int SUPPLY_MV = 5000) (
    input  wire logic [31:0]      codes,
    output logic      [3:0][15:0] mv
);
    timeunit 1ns;
    timeprecision 1ns;
    always_comb for (int n = 0; n < 4; n++) mv[n] = 16'(codes[8*n +: 8] * SUPPLY_MV / 256);
endmodule

// ---- tb/converter_ctrl_tb_top.sv ----
// Register-level test of the converter control
module converter_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic             clk = 0, rstn = 0, ce = 1, hw = 0, idle = 0, wr = 0, rd = 0, rvalid, run;
    logic [2:0]       addr = 0;
    logic [7:0]       wdata = 0, rdata;
    logic [3:0]       act, start, last_start = 0;
    logic [31:0]      pins;
    logic [3:0][15:0] mv;
    int               n_mismatch = 0, cmp_count = 0, cyc = 0;
    converter_ctrl dut (.clk, .rstn, .ce, .hardware_reset_pin(hw), .idle_mode(idle), .reg_addr(addr),
        .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid),
        .analog_out_pins(pins), .channel_active(act), .conv_start(start), .converter_run(run));
    analog_load load (.codes(pins), .mv);
    initial forever #10 clk = ~clk;
    always @(posedge clk) if (++cyc == 3000) begin n_mismatch++; report_and_stop(); end
    task automatic ck(string what, logic [31:0] e, logic [31:0] s);
        cmp_count++;
        if (s !== e) begin n_mismatch++; $display("unexpected %s expected %h seen %h", what, e, s); end
    endtask
    task automatic step(int k); repeat (k) @(posedge clk); #1; endtask
    // Strobe dropped a full cycle before the next request
    task automatic wr_reg(logic [2:0] a, logic [7:0] d);
        addr = a; wdata = d; wr = 1; step(1); wr = 0; last_start = start; step(1);
    endtask
    task automatic rd_reg(logic [2:0] a, logic [7:0] e);
        addr = a; rd = 1; step(1); rd = 0;
        ck("rvalid", 1, rvalid); ck("rdata", e, rdata); step(1);
    endtask
    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        step(5); rstn = 1;
        ck("pins", 0, pins);
        ck("active", 0, act);
        rd_reg(0, 8'h00);
        for (int i = 1; i < 5; i++) begin
            wr_reg(3'(i), 8'h00);
            ck("start", 0, last_start);
        end
        wr_reg(0, 8'hFF);
        rd_reg(0, 8'h0F);
        for (int i = 1; i < 5; i++) begin
            wr_reg(3'(i), 8'(64 * i - 1));
            ck("start", 4'h1 << (i - 1), last_start);
        end
        step(1); ck("pins", 32'hFFBF7F3F, pins);
        ck("run", 1, run);
        ck("mv3", 16'(255 * 5000 / 256), mv[3]);
        ck("mv0", 16'(63 * 5000 / 256), mv[0]);
        for (int i = 1; i < 5; i++) rd_reg(3'(i), 8'(64 * i - 1));
        wr_reg(0, 8'h05); step(1); ck("pins", 32'h00BF003F, pins);
        ck("active", 4'h5, act);
        wr_reg(2, 8'h7F); ck("start", 0, last_start);
        ce = 0; wr_reg(0, 8'h0F); ce = 1; rd_reg(0, 8'h05);
        idle = 1; step(1); ck("pins", 0, pins); ck("run", 0, run);
        ck("active", 0, act);
        wr_reg(3, 8'hBF); ck("start", 0, last_start);
        rd_reg(0, 8'h05); rd_reg(3, 8'hBF);
        idle = 0; rd_reg(5, 8'h00);
        ck("pins", 32'h00BF003F, pins);
        hw = 1; step(1); hw = 0; rd_reg(0, 8'h00); ck("pins", 0, pins);
        ck("run", 0, run);
        report_and_stop();
    end
endmodule
